// >>> core/scp_port.sv
// Programming port: serial shifter on the host shift clock, parallel strobes,
// direct pins, staging and active counter words, and the counter value mux.
// Assumes all pins except sys_rst_in are asynchronous to clk_in; all but the serial shift clock and serial data pins are resynchronised here.
`timescale 1ns/1ps
`default_nettype none

module scp_port #(
  parameter int SYNC_STAGES = scp_pkg::SYNC_STAGES
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic serial_shift_clock_in,
  input wire logic serial_in,
  input wire logic serial_load_strobe_in,
  input wire logic ext_reg_write_in,
  input wire logic hop_strobe_in,
  input wire logic high_divider_write_in,
  input wire logic low_divider_write_in,
  input wire logic swallow_ref_write_in,
  input wire logic [scp_pkg::BYTE_W-1:0] par_data_in,
  input wire logic direct_select_in,
  input wire logic serial_select_in,
  input wire logic serial_bank_select_in,
  input wire logic parallel_bank_select_in,
  input wire logic [scp_pkg::DIV_W-1:0] direct_divider_in,
  input wire logic [scp_pkg::REF_W-1:0] direct_reference_in,
  input wire logic [scp_pkg::SWL_W-1:0] direct_swallow_in,
  input wire logic prescaler_enable_n_in,
  output logic [scp_pkg::DIV_W-1:0] divider_out,
  output logic [scp_pkg::REF_W-1:0] reference_out,
  output logic [scp_pkg::SWL_W-1:0] swallow_out,
  output logic prescaler_enable_n_out,
  output logic [scp_pkg::BYTE_W-1:0] feature_control_out
);

  localparam int WW = scp_pkg::WORD_W;
  localparam int BW = scp_pkg::BYTE_W;
  // Width of the resynchronised bundle: shift words, bus, strobes, modes, pins.
  localparam int AW = WW + BW + BW + 6 + 4 + scp_pkg::DIV_W + scp_pkg::REF_W
                      + scp_pkg::SWL_W + 1;

  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // Shift clock domain. No reset exists on the host side, so the shifters
  // hold whatever the host last clocked in.
  logic [WW-1:0] shift_word_r;
  logic [WW-1:0] shift_word_nxt;
  logic [BW-1:0] shift_byte_r;
  logic [BW-1:0] shift_byte_nxt;

  always_comb begin
    shift_word_nxt = shift_word_r;
    shift_byte_nxt = shift_byte_r;
    if (!serial_load_strobe_in) begin
      if (ext_reg_write_in) begin
        shift_byte_nxt = {shift_byte_r[BW-2:0], serial_in};
      end else begin
        shift_word_nxt = {shift_word_r[WW-2:0], serial_in};
      end
    end
  end

  always_ff @(posedge serial_shift_clock_in) begin
    shift_word_r <= shift_word_nxt;
    shift_byte_r <= shift_byte_nxt;
  end

  // Everything entering clk_in except sys_rst_in passes the synchroniser chain. The shift words
  // are quiet whenever a load strobe edge is seen, so the strobe edge acts as
  // the handshake that makes the word safe to take.
  logic [AW-1:0] sync_r [SYNC_STAGES];
  logic [AW-1:0] async_w;

  assign async_w = {shift_word_r, shift_byte_r, par_data_in,
                    ext_reg_write_in, hop_strobe_in, high_divider_write_in,
                    low_divider_write_in, swallow_ref_write_in,
                    serial_load_strobe_in,
                    direct_select_in, serial_select_in, serial_bank_select_in,
                    parallel_bank_select_in,
                    direct_divider_in, direct_reference_in, direct_swallow_in,
                    prescaler_enable_n_in};

  always_ff @(posedge clk_in) begin
    sync_r[0] <= async_w;
    for (int i = 1; i < SYNC_STAGES; i++) begin
      sync_r[i] <= sync_r[i-1];
    end
  end

  logic [WW-1:0] s_word;
  logic [BW-1:0] s_byte;
  logic [BW-1:0] s_data;
  logic [5:0] s_strb;
  logic s_direct;
  logic s_serial;
  logic s_sbank;
  logic s_pbank;
  logic [scp_pkg::DIV_W-1:0] s_div;
  logic [scp_pkg::REF_W-1:0] s_ref;
  logic [scp_pkg::SWL_W-1:0] s_swl;
  logic s_pre_n;

  assign {s_word, s_byte, s_data, s_strb, s_direct, s_serial, s_sbank, s_pbank,
          s_div, s_ref, s_swl, s_pre_n} = sync_r[SYNC_STAGES-1];

  // Strobe edge detection, order: ext, hop, high, low, swallow/ref, load.
  logic [5:0] strb_prev_r;
  logic [5:0] strb_prev_nxt;
  logic [5:0] rise_w;
  logic [5:0] fall_w;

  assign strb_prev_nxt = s_strb;
  assign rise_w = s_strb & ~strb_prev_r;
  assign fall_w = ~s_strb & strb_prev_r;

  // Follows the pins through reset too, so a strobe resting low is not taken as a fall.
  always_ff @(posedge clk_in) begin
    strb_prev_r <= strb_prev_nxt;
  end

  logic ewr_rise;
  logic ewr_fall;
  logic hop_rise;
  logic hi_rise;
  logic lo_rise;
  logic sr_rise;
  logic load_rise;

  assign ewr_rise = rise_w[5];
  assign ewr_fall = fall_w[5];
  assign hop_rise = rise_w[4];
  assign hi_rise = rise_w[3];
  assign lo_rise = rise_w[2];
  assign sr_rise = rise_w[1];
  assign load_rise = rise_w[0];

  scp_pkg::scp_mode_t mode_w;

  always_comb begin
    if (s_direct) begin
      mode_w = scp_pkg::SCP_MODE_DIRECT;
    end else if (s_serial) begin
      mode_w = scp_pkg::SCP_MODE_SERIAL;
    end else begin
      mode_w = scp_pkg::SCP_MODE_PARALLEL;
    end
  end

  // Staging word, active word and feature byte.
  logic [WW-1:0] staging_counter_word_r;
  logic [WW-1:0] staging_counter_word_nxt;
  logic [WW-1:0] active_word_r;
  logic [WW-1:0] active_word_nxt;
  logic [BW-1:0] feature_control_byte_r;
  logic [BW-1:0] feature_control_byte_nxt;
  logic xfer_w;

  always_comb begin
    staging_counter_word_nxt = staging_counter_word_r;
    active_word_nxt = active_word_r;
    feature_control_byte_nxt = feature_control_byte_r;
    xfer_w = 1'b0;
    unique case (mode_w)
      scp_pkg::SCP_MODE_SERIAL: begin
        if (load_rise) begin
          // The freshly shifted word becomes staging and active at once.
          staging_counter_word_nxt = s_word;
          active_word_nxt = s_word;
          xfer_w = 1'b1;
        end else if (hop_rise) begin
          active_word_nxt = staging_counter_word_r;
          xfer_w = 1'b1;
        end
        if (ewr_fall) begin
          feature_control_byte_nxt = s_byte;
        end
      end
      scp_pkg::SCP_MODE_PARALLEL: begin
        if (hi_rise) begin
          staging_counter_word_nxt[scp_pkg::REF_LSB+4 +: 2] =
            s_data[scp_pkg::HI_REF_LSB +: 2];
          staging_counter_word_nxt[scp_pkg::DIV_LSB+7 +: 2] =
            s_data[scp_pkg::HI_DIV_LSB +: 2];
        end
        if (lo_rise) begin
          staging_counter_word_nxt[scp_pkg::PRE_BIT] = s_data[scp_pkg::LO_PRE_BIT];
          staging_counter_word_nxt[scp_pkg::DIV_LSB +: 7] = s_data[6:0];
        end
        if (sr_rise) begin
          staging_counter_word_nxt[scp_pkg::REF_LSB +: 4] =
            s_data[scp_pkg::SR_REF_LSB +: 4];
          staging_counter_word_nxt[scp_pkg::SWL_LSB +: 4] =
            s_data[scp_pkg::SR_SWL_LSB +: 4];
        end
        if (hop_rise || load_rise) begin
          active_word_nxt = staging_counter_word_r;
          xfer_w = 1'b1;
        end
        if (ewr_rise) begin
          feature_control_byte_nxt = s_data;
        end
      end
      scp_pkg::SCP_MODE_DIRECT: begin
        // Load paths are ignored while the pins are in charge.
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      staging_counter_word_r <= '0;
      active_word_r <= '0;
      feature_control_byte_r <= '0;
    end else begin
      staging_counter_word_r <= staging_counter_word_nxt;
      active_word_r <= active_word_nxt;
      feature_control_byte_r <= feature_control_byte_nxt;
    end
  end

  // Counter value selection, registered so every output comes from a flop.
  logic [WW-1:0] src_word;
  logic [scp_pkg::DIV_W-1:0] div_nxt;
  logic [scp_pkg::REF_W-1:0] ref_nxt;
  logic [scp_pkg::SWL_W-1:0] swl_nxt;
  logic pre_nxt;

  always_comb begin
    src_word = active_word_r;
    unique case (mode_w)
      scp_pkg::SCP_MODE_SERIAL: begin
        src_word = s_sbank ? staging_counter_word_r : active_word_r;
      end
      scp_pkg::SCP_MODE_PARALLEL: begin
        src_word = s_pbank ? staging_counter_word_r : active_word_r;
      end
      scp_pkg::SCP_MODE_DIRECT: begin
        src_word = active_word_r;
      end
    endcase
    if (mode_w == scp_pkg::SCP_MODE_DIRECT) begin
      div_nxt = s_div;
      ref_nxt = s_ref;
      swl_nxt = s_swl;
      pre_nxt = s_pre_n;
    end else begin
      div_nxt = src_word[scp_pkg::DIV_LSB +: scp_pkg::DIV_W];
      ref_nxt = src_word[scp_pkg::REF_LSB +: scp_pkg::REF_W];
      swl_nxt = src_word[scp_pkg::SWL_LSB +: scp_pkg::SWL_W];
      pre_nxt = src_word[scp_pkg::PRE_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      divider_out <= '0;
      reference_out <= '0;
      swallow_out <= '0;
      prescaler_enable_n_out <= 1'b0;
      feature_control_out <= '0;
    end else begin
      divider_out <= div_nxt;
      reference_out <= ref_nxt;
      swallow_out <= swl_nxt;
      prescaler_enable_n_out <= pre_nxt;
      feature_control_out <= feature_control_byte_nxt;
    end
  end

  // Checks.
  shift_word_a: assert property (@(posedge serial_shift_clock_in) disable iff (sys_rst_in)
    (!serial_load_strobe_in && !ext_reg_write_in) |=>
      shift_word_r === {$past(shift_word_r[WW-2:0]), $past(serial_in)})
    else $error("staging shifter did not shift");

  shift_hold_a: assert property (@(posedge serial_shift_clock_in) disable iff (sys_rst_in)
    serial_load_strobe_in |=> $stable(shift_word_r) && $stable(shift_byte_r))
    else $error("shifter moved while load strobe high");

  hop_copy_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (hop_rise && !load_rise && mode_w != scp_pkg::SCP_MODE_DIRECT) |=>
      active_word_r == $past(staging_counter_word_r))
    else $error("hop edge did not copy staging word");

  active_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !xfer_w |=> $stable(active_word_r))
    else $error("active word changed without transfer");

  serial_bank_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (mode_w == scp_pkg::SCP_MODE_SERIAL && !s_sbank) |=>
      divider_out == $past(active_word_r[scp_pkg::DIV_LSB +: scp_pkg::DIV_W]))
    else $error("serial mode did not drive from active word");

  par_bank_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (mode_w == scp_pkg::SCP_MODE_PARALLEL && s_pbank) |=>
      swallow_out == $past(staging_counter_word_r[scp_pkg::SWL_LSB +: 4]))
    else $error("parallel mode did not drive from staging word");

  direct_pins_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (mode_w == scp_pkg::SCP_MODE_DIRECT) |=> divider_out == $past(s_div)
      && reference_out == $past(s_ref) && prescaler_enable_n_out == $past(s_pre_n))
    else $error("direct mode did not follow pins");

  direct_ignore_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (mode_w == scp_pkg::SCP_MODE_DIRECT) |=> $stable(staging_counter_word_r))
    else $error("load path acted in direct mode");

  ext_byte_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (mode_w == scp_pkg::SCP_MODE_PARALLEL && ewr_rise) |=>
      feature_control_out == $past(s_data))
    else $error("feature byte not latched");

  hi_field_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (mode_w == scp_pkg::SCP_MODE_PARALLEL && hi_rise) |=>
      staging_counter_word_r[scp_pkg::REF_LSB+4 +: 2] == $past(s_data[3:2])
      && staging_counter_word_r[scp_pkg::DIV_LSB+7 +: 2] == $past(s_data[1:0]))
    else $error("high divider fields wrong");

  lo_field_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (mode_w == scp_pkg::SCP_MODE_PARALLEL && lo_rise) |=>
      staging_counter_word_r[scp_pkg::PRE_BIT] == $past(s_data[7]))
    else $error("low divider fields wrong");

  sr_field_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (mode_w == scp_pkg::SCP_MODE_PARALLEL && sr_rise) |=>
      staging_counter_word_r[scp_pkg::SWL_LSB +: 4] == $past(s_data[3:0]))
    else $error("swallow fields wrong");

  serial_load_c: cover property (@(posedge clk_in) mode_w == scp_pkg::SCP_MODE_SERIAL
    && load_rise);
  par_hop_c: cover property (@(posedge clk_in) mode_w == scp_pkg::SCP_MODE_PARALLEL
    && hop_rise);
  direct_c: cover property (@(posedge clk_in) mode_w == scp_pkg::SCP_MODE_DIRECT);

endmodule // scp_port

`default_nettype wire

// >>> core/scp_pkg.sv
// Constants for the synthesizer counter programming port: field layout of
// the staging word, parallel byte field positions and synchroniser depth.
// Assumes a single system clock plus a serial shift clock driven by the host.

package scp_pkg;

  localparam int DIV_W = 9;
  localparam int REF_W = 6;
  localparam int SWL_W = 4;
  localparam int WORD_W = 20;
  localparam int BYTE_W = 8;

  // Staging word layout: {prescaler_enable_n, reference, divider, swallow}.
  localparam int SWL_LSB = 0;
  localparam int DIV_LSB = 4;
  localparam int REF_LSB = 13;
  localparam int PRE_BIT = 19;

  // Parallel byte field positions.
  localparam int HI_DIV_LSB = 0;
  localparam int HI_REF_LSB = 2;
  localparam int LO_PRE_BIT = 7;
  localparam int SR_SWL_LSB = 0;
  localparam int SR_REF_LSB = 4;

  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    SCP_MODE_SERIAL = 3'h1,
    SCP_MODE_PARALLEL = 3'h2,
    SCP_MODE_DIRECT = 3'h4
  } scp_mode_t;

endpackage : scp_pkg

// >>> test/scp_host_model.sv
// Host model for the counter programming port: drives the serial link pins.
// Assumes the bench calls its tasks one at a time; the shift clock runs in frames and in stray bursts.
`timescale 1ns/1ps
`default_nettype none

module scp_host_model (
  output logic sclk_out,
  output logic sdata_out,
  output logic load_strobe_out,
  output logic ext_write_out
);
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    load_strobe_out = 1'b1;
    ext_write_out = 1'b0;
  end

  // One frame of nbits, first bit from the top; zero bits just pulses the load strobe again.
  task automatic frame(input logic [19:0] w, input int nbits, input logic to_ext);
    load_strobe_out = 1'b0;
    ext_write_out = to_ext;
    #43;
    for (int i = nbits - 1; i >= 0; i--) begin
      sdata_out = w[i];
      #16 sclk_out = 1'b1;
      #16 sclk_out = 1'b0;
    end
    // The data line is not held after the frame, so it shows the opposite level.
    sdata_out = ~sdata_out;
    #40 ext_write_out = 1'b0;
    // The strobe rises only once every bit is in, so the word moves as one set.
    #40 load_strobe_out = 1'b1;
    #40;
  endtask

  // Shift clocks with the strobe high; a correct port must ignore them.
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      sdata_out = ~sdata_out;
      #16 sclk_out = 1'b1;
      #16 sclk_out = 1'b0;
    end
    #40;
  endtask
endmodule // scp_host_model

`default_nettype wire

// >>> test/test_synth_counter_program_port.sv
// Testbench for the counter programming port: serial, parallel and direct paths.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_synth_counter_program_port;
  localparam int LIMIT = 20000;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic sclk, sdata, sload, sext;
  logic pext = 1'b0;
  logic hop = 1'b0, hiw = 1'b0, low = 1'b0, srw = 1'b0;
  logic [7:0] pd = 8'h00;
  logic dsel = 1'b0, ssel = 1'b1, sbank = 1'b0, pbank = 1'b0, dpre = 1'b0;
  logic [8:0] ddiv = 9'h000;
  logic [5:0] dref = 6'h00;
  logic [3:0] dswl = 4'h0;
  logic [8:0] div;
  logic [5:0] rf;
  logic [3:0] swl;
  logic pre;
  logic [7:0] feat;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  // The enhancement write pin is shared: the host owns it whenever ssel is high.
  wire logic ext = ssel ? sext : pext;
  wire logic [19:0] cnt = {pre, rf, div, swl};
  logic [19:0] wa, wb;

  always #2 clk_in = ~clk_in;

  scp_host_model scp_host_model_inst (.sclk_out(sclk), .sdata_out(sdata),
    .load_strobe_out(sload), .ext_write_out(sext));

  scp_port scp_port_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .serial_shift_clock_in(sclk), .serial_in(sdata), .serial_load_strobe_in(sload),
    .ext_reg_write_in(ext), .hop_strobe_in(hop), .high_divider_write_in(hiw),
    .low_divider_write_in(low), .swallow_ref_write_in(srw), .par_data_in(pd),
    .direct_select_in(dsel), .serial_select_in(ssel), .serial_bank_select_in(sbank),
    .parallel_bank_select_in(pbank), .direct_divider_in(ddiv), .direct_reference_in(dref),
    .direct_swallow_in(dswl), .prescaler_enable_n_in(dpre), .divider_out(div),
    .reference_out(rf), .swallow_out(swl), .prescaler_enable_n_out(pre),
    .feature_control_out(feat));

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [19:0] exp, input logic [19:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Word order is prescaler enable, reference, divider, swallow from the top.
  function automatic logic [19:0] pk(logic p, logic [5:0] r, logic [8:0] d, logic [3:0] s);
    return {p, r, d, s};
  endfunction

  // Strobe index: 0 high divider, 1 low divider, 2 swallow/reference, 3 ext, 4 hop.
  task automatic pwr(input int which, input logic [7:0] d);
    @(posedge clk_in) pd <= d;
    tick(4);
    case (which)
      0: hiw <= 1'b1;
      1: low <= 1'b1;
      2: srw <= 1'b1;
      3: pext <= 1'b1;
      default: hop <= 1'b1;
    endcase
    tick(5);
    {hiw, low, srw, pext, hop} <= 5'h00;
    tick(6);
  endtask

  task automatic t_reset();
    check("counters after reset", 20'h00000, cnt);
    check("feature after reset", 20'h00000, {12'h000, feat});
  endtask

  task automatic t_serial();
    scp_host_model_inst.frame(wa, 20, 1'b0);
    tick(8);
    check("serial word", wa, cnt);
    scp_host_model_inst.stray(6);
    scp_host_model_inst.frame(20'h00000, 0, 1'b0);
    tick(8);
    check("shift with strobe high", wa, cnt);
    scp_host_model_inst.frame(20'h000C3, 8, 1'b1);
    tick(8);
    check("serial feature", 20'h000C3, {12'h000, feat});
    check("word after feature", wa, cnt);
  endtask

  task automatic t_parallel();
    @(posedge clk_in) ssel <= 1'b0;
    tick(8);
    pwr(4, 8'h00);
    pwr(0, 8'h0E);
    pwr(1, 8'h95);
    pwr(2, 8'h6C);
    tick(4);
    check("active held", wa, cnt);
    pbank <= 1'b1;
    tick(8);
    check("staging view", wb, cnt);
    ssel <= 1'b1;
    tick(8);
    check("serial bank view", wa, cnt);
    sbank <= 1'b1;
    tick(8);
    check("serial staging view", wb, cnt);
    sbank <= 1'b0;
    ssel <= 1'b0;
    pbank <= 1'b0;
    tick(8);
    check("parallel bank view", wa, cnt);
    pwr(4, 8'h00);
    tick(4);
    check("after hop", wb, cnt);
    pwr(3, 8'h5A);
    tick(4);
    check("parallel feature", 20'h0005A, {12'h000, feat});
  endtask

  task automatic t_direct();
    @(posedge clk_in) dsel <= 1'b1;
    ddiv <= 9'h1C3;
    dref <= 6'h25;
    dswl <= 4'hA;
    dpre <= 1'b1;
    tick(8);
    check("direct pins", pk(1'b1, 6'h25, 9'h1C3, 4'hA), cnt);
    pwr(2, 8'hFF);
    pwr(4, 8'h00);
    dpre <= 1'b0;
    tick(8);
    check("direct prescaler", pk(1'b0, 6'h25, 9'h1C3, 4'hA), cnt);
    dsel <= 1'b0;
    pbank <= 1'b1;
    tick(8);
    check("load ignored in direct", wb, cnt);
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    wa = pk(1'b1, 6'h2D, 9'h1A5, 4'h9);
    wb = pk(1'b1, 6'h36, 9'h115, 4'hC);
    tick(20);
    sys_rst_in <= 1'b0;
    tick(4);
    t_reset();
    t_serial();
    t_parallel();
    t_direct();
    stop_test();
  end
endmodule // test_synth_counter_program_port

`default_nettype wire
